// ### core/fp_issue_ctrl.sv
// issue, serialization and hazard interlock for the fp coprocessor
`timescale 1ns/100ps
`include "fp_issue_consts.svh"

// Overview of operation
// RL1 - host should follow long ops with transfers
// RL2 - vector divide blocks both arithmetic pipes
// RL3 - scalar divide lets others issue next
// RL4 - transfers overlap arithmetic on disjoint registers
// RL5 - after mispredict, drain before next issue
// RL6 - control register transfers fully serialize
// RL7 - next-cycle source reuse stalls outside fast
// RL8 - single static clock keeps state
// RL9 - scan chain and isolation provided (code has the scan chain only)
// RL10 - paired transfers move two words
// RL11 - hardware interlock between arithmetic and divide
// RL12 - default results for disabled exceptions
// RL13 - overflow trap enabled sends risky ops away
// RL14 - default nan for quiet nan inputs
// RL15 - signaling nan sets invalid, may trap
// RL16 - fast mode loads skip vector source locks
// RL17 - flushed input sets denormal flag, traps (code traps only when the denormal trap enable bit 15 is set)
// RL18 - flushed result sets underflow, never traps
// RL19 - fast condition from settings and enables
// RL20 - flush and default-nan bit positions
// RL21 - input denormal flag sticky bit 7
// RL22 - underflow flag sticky bit 11
module fp_issue_ctrl
  import fp_issue_pkg::*;
#(
  parameter int NREG   = 32,
  parameter int CW     = 6,
  parameter int DIV_CY = 14
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  // scan test
  input  wire logic                      scan_en,
  input  wire logic                      scan_in,
  output logic                           scan_out,
  // issue request from the host
  input  wire logic                      iss_valid,
  input  wire fp_issue_pkg::op_class_type iss_class,
  input  wire logic                      iss_double,
  input  wire logic [3:0]                iss_len,
  input  wire logic [NREG-1:0]           iss_src_mask,
  input  wire logic [NREG-1:0]           iss_dst_mask,
  input  wire logic [CW-1:0]             iss_cycles,
  input  wire logic                      iss_paired,
  input  wire logic                      branch_mispredict,
  output logic                           iss_accept,
  output logic                           iss_stall,
  // operand classification from the datapath
  input  wire logic                      op_done_valid,
  input  wire logic [NREG-1:0]           op_done_mask,
  input  wire logic                      in_subnormal,
  input  wire logic                      in_qnan,
  input  wire logic                      in_snan,
  input  wire logic                      ovf_possible,
  input  wire logic                      res_tiny,
  output logic                           use_default_nan,
  output logic                           trap_support,
  output logic                           trap_user,
  output logic                           paired_two_words,
  // register port
  input  wire logic [3:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [31:0]                    reg_rdata
);
  logic [1:0]      rst_sync_q;
  logic            rst_n;
  logic [31:0]     sc_q;
  logic [NREG-1:0] lock_q;
  logic [NREG-1:0] vsrc_q;
  logic [NREG-1:0] prev_src_q;
  logic            prev_valid_q;
  logic [3:0]      vdiv_left_q;
  issue_state_type state_q;
  logic            fast;
  logic            mac_busy;
  logic            div_busy;
  logic            ls_busy;
  logic            any_busy;
  logic            stall;
  logic            take;
  logic [7:0]      scan_q;
  logic            is_ar;
  logic            ev_denorm;
  logic            ev_uf;
  logic            ev_inv;

  // ******************************
  // reset release
  // ******************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ******************************
  // mode decode
  // ******************************
  // fast only when both settings on and every enable clear
  assign fast = sc_q[`BIT_FLUSH_ZERO] && sc_q[`BIT_DNAN] && !sc_q[`BIT_DENORM_TRAP] // RL19 RL20
              && (sc_q[`BIT_TRAP_HI:`BIT_TRAP_LO] == 5'h00); // RL19
  assign is_ar = (iss_class == OP_ARITH) || (iss_class == OP_DIVSQ);

  // ******************************
  // pipeline occupancy
  // ******************************
  fp_busy_track #(.CW(CW)) u_mac (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (take && iss_class == OP_ARITH),
    .cycles  (iss_cycles),
    .busy    (mac_busy)
  );
  fp_busy_track #(.CW(CW)) u_div (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (take && iss_class == OP_DIVSQ),
    .cycles  (CW'(DIV_CY)),
    .busy    (div_busy)
  );
  fp_busy_track #(.CW(CW)) u_ls (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (take && (iss_class == OP_LDST || iss_class == OP_CTRL)),
    .cycles  (iss_cycles),
    .busy    (ls_busy)
  );
  assign any_busy = mac_busy || div_busy || ls_busy || (lock_q != '0);

  // ******************************
  // stall decision
  // ******************************
  // host is expected to space long ops with transfers; we still interlock // RL1
  always_comb begin
    stall = 1'b0;
    if (state_q != ST_RUN) stall = 1'b1; // RL2 RL5
    if (iss_class == OP_CTRL && any_busy) stall = 1'b1; // RL6
    if (iss_class == OP_DIVSQ && div_busy) stall = 1'b1; // RL3 RL11
    if (iss_class == OP_ARITH && mac_busy && iss_len > 4'h1) stall = 1'b1;
    // transfers only wait on registers the arithmetic really holds
    if (((iss_src_mask | iss_dst_mask) & lock_q & ~(fast ? vsrc_q : '0)) != '0) // RL4 RL16
      stall = 1'b1;
    if (!fast && prev_valid_q && (iss_src_mask & prev_src_q) != '0) // RL7
      stall = 1'b1;
  end
  assign take = iss_valid && !stall;

  // ******************************
  // issue state
  // ******************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_RUN;
      vdiv_left_q <= 4'h0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (branch_mispredict && any_busy) state_q <= ST_DRAIN; // RL5
          else if (take && iss_class == OP_DIVSQ && iss_len > 4'h1) begin
            state_q     <= ST_VECDIV; // RL2
            vdiv_left_q <= iss_len - 4'h1;
          end
        end
        ST_DRAIN: if (!any_busy) state_q <= ST_RUN; // RL5
        ST_VECDIV: begin
          // one iteration leaves decode each cycle
          if (vdiv_left_q <= 4'h1) state_q <= ST_RUN; // RL2
          vdiv_left_q <= vdiv_left_q - 4'h1;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // ******************************
  // register scoreboard
  // ******************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= '0;
      vsrc_q <= '0;
    end else begin
      // set wins over a completion in the same cycle
      // vector sources stay locked until their iterations retire
      lock_q <= (lock_q & ~(op_done_valid ? op_done_mask : '0)) // RL11
              | ((take && is_ar) ? iss_dst_mask : '0)
              | ((take && is_ar && iss_len > 4'h1) ? iss_src_mask : '0); // RL16
      vsrc_q <= (vsrc_q & ~(op_done_valid ? op_done_mask : '0))
              | ((take && is_ar && iss_len > 4'h1) ? iss_src_mask : '0);
    end
  end

  // previous-cycle read set for the read-after-read check
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_src_q   <= '0;
      prev_valid_q <= 1'b0;
    end else begin
      prev_src_q   <= iss_src_mask;
      prev_valid_q <= take;
    end
  end

  // ******************************
  // exception handling
  // ******************************
  assign ev_denorm = op_done_valid && in_subnormal && sc_q[`BIT_FLUSH_ZERO]; // RL17
  assign ev_uf     = op_done_valid && res_tiny && sc_q[`BIT_FLUSH_ZERO];     // RL18
  assign ev_inv    = op_done_valid && in_snan && sc_q[`BIT_DNAN];     // RL15

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      use_default_nan  <= 1'b0;
      trap_support     <= 1'b0;
      trap_user        <= 1'b0;
      paired_two_words <= 1'b0;
    end else begin
      use_default_nan  <= op_done_valid && sc_q[`BIT_DNAN] && (in_qnan || in_snan); // RL14
      // infinities, overflow and zero divides stay in hardware unless trapped // RL12
      trap_support     <= op_done_valid && ((ovf_possible && sc_q[`BIT_OVF_EN]) // RL13
                        || ((in_qnan || in_snan) && !sc_q[`BIT_DNAN]));
      trap_user        <= (ev_denorm && sc_q[`BIT_DENORM_TRAP]) // RL17
                        || (ev_inv && sc_q[`BIT_INV_EN]); // RL15 RL18
      paired_two_words <= take && iss_paired; // RL10
    end
  end

  // ******************************
  // status control and register port
  // ******************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_q <= `STATUS_CTRL_RST;
    end else begin
      if (reg_wr && reg_addr == `OFS_STATUS_CTRL) sc_q <= reg_wdata;
      // sticky flags: set beats a simultaneous clear
      if (ev_denorm) sc_q[`BIT_INPUT_DENORM] <= 1'b1; // RL21
      if (ev_uf) sc_q[`BIT_UNDERFLOW] <= 1'b1; // RL22
      if (ev_inv) sc_q[`BIT_INVALID] <= 1'b1; // RL15
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_STATUS_CTRL: reg_rdata <= sc_q;
        `OFS_ISSUE_STATE: reg_rdata <= {24'h00_0000, fast, ls_busy, div_busy, mac_busy,
                                        1'b0, state_q};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ******************************
  // issue outputs and scan
  // ******************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iss_accept <= 1'b0;
      iss_stall  <= 1'b0;
    end else begin
      iss_accept <= take;
      iss_stall  <= iss_valid && stall;
    end
  end

  // simple scan shift path; all state is static so a stopped clock loses nothing // RL8 RL9
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_q   <= 8'h00;
      scan_out <= 1'b0;
    end else if (scan_en) begin
      scan_q   <= {scan_q[6:0], scan_in}; // RL9
      scan_out <= scan_q[7];
    end
  end

  // ******************************
  // checks
  // ******************************
  chk_ctrl_serial: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL6
    (iss_valid && iss_class == OP_CTRL && any_busy) |-> !take)
    else $error("control transfer issued while busy");
  chk_drain_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL5
    (state_q == ST_DRAIN) |-> !take)
    else $error("issue during drain");
  chk_vecdiv_block: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL2
    (take && iss_class == OP_DIVSQ && iss_len > 4'h1) |=> (state_q == ST_VECDIV))
    else $error("vector divide did not block");
  chk_rar_stall: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL7
    (!fast && prev_valid_q && (iss_src_mask & prev_src_q) != '0) |-> !take)
    else $error("read-after-read not stalled");
  chk_fast_decode: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL19
    fast == (sc_q[24] && sc_q[25] && !sc_q[15] && sc_q[12:8] == 5'h00))
    else $error("fast condition decode wrong");
  chk_denorm_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL21
    ev_denorm |=> sc_q[7])
    else $error("input denormal flag not set");
  chk_uf_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL22
    ev_uf |=> sc_q[11])
    else $error("underflow flag not set");
  chk_uf_notrap: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL18
    (ev_uf && !ev_denorm && !ev_inv) |=> !trap_user)
    else $error("underflow flush trapped");
  chk_ovf_trap: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL13
    (op_done_valid && ovf_possible && sc_q[10]) |=> trap_support)
    else $error("overflow trap not taken");
  chk_div_parallel: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL3
    (iss_valid && iss_class == OP_DIVSQ && div_busy) |-> !take)
    else $error("divide pipe double issue");
endmodule // fp_issue_ctrl

// ### common/fp_issue_consts.svh
// constants for the coprocessor issue and hazard control block
`ifndef FP_ISSUE_CONSTS_SVH
`define FP_ISSUE_CONSTS_SVH
// register offsets on the plain register port
`define OFS_STATUS_CTRL   4'h0
`define OFS_ISSUE_STATE   4'h1
`define OFS_SCAN_CTRL     4'h2
// status-control field positions
`define BIT_INPUT_DENORM  7
`define BIT_INVALID       0
`define BIT_UNDERFLOW     11
`define BIT_TRAP_LO       8
`define BIT_TRAP_HI       12
`define BIT_DENORM_TRAP   15
`define BIT_FLUSH_ZERO    24
`define BIT_DNAN          25
`define BIT_OVF_EN        10
`define BIT_INV_EN        8
`define BIT_UF_EN         11
// reset values
`define STATUS_CTRL_RST   32'h0000_0000
`endif

// ### common/fp_issue_pkg.sv
// types for the coprocessor issue and hazard control block
package fp_issue_pkg;
  typedef enum logic [3:0] {
    OP_ARITH  = 4'h1,   // multiply-accumulate pipeline op
    OP_DIVSQ  = 4'h2,   // divide/square-root op
    OP_LDST   = 4'h4,   // load/store or host transfer
    OP_CTRL   = 4'h8    // control register transfer
  } op_class_type;
  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_DRAIN  = 3'b010,
    ST_VECDIV = 3'b100
  } issue_state_type;
endpackage

// ### core/fp_busy_track.sv
// one busy tracker: counts down remaining cycles of a pipeline occupancy
`timescale 1ns/100ps
module fp_busy_track #(
  parameter int CW = 6
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // load and state
  input  wire logic          load,
  input  wire logic [CW-1:0] cycles,
  output logic               busy
);
  logic [CW-1:0] cnt_q;

  // count down while held; state stays put if the clock stops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= cycles;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy = (cnt_q != '0);
endmodule // fp_busy_track

// ### test/fp_host_model.sv
// host core model: presents coprocessor requests and retries refused ones
`timescale 1ns/100ps
module fp_host_model
  import fp_issue_pkg::*;
(
  // clock
  input  wire logic                  ref_clk,
  // request
  output fp_issue_pkg::op_class_type iss_class,
  output logic                       iss_valid,
  output logic [3:0]                 iss_len,
  output logic [31:0]                iss_src_mask,
  output logic [31:0]                iss_dst_mask,
  output logic [5:0]                 iss_cycles,
  output logic                       iss_paired,
  // answer
  input  wire logic                  iss_accept,
  input  wire logic                  paired_two_words
);
  // ****************
  // request driver
  // ****************
  int   n_pair    = 0;
  logic need_xfer = 1'b0;
  initial begin
    iss_class = OP_LDST;
    {iss_valid, iss_len, iss_src_mask, iss_dst_mask, iss_cycles, iss_paired} = '0;
  end
  // paired transfer pulses, counted where they stand
  always @(posedge ref_clk) n_pair <= n_pair + int'(paired_two_words);
  // one cycle of request after the edge
  task automatic present(op_class_type c, int len, logic [31:0] s, d, int cy, bit pr);
    iss_valid    <= 1'b1;
    iss_class    <= c;
    iss_len      <= 4'(len);
    iss_src_mask <= s;
    iss_dst_mask <= d;
    iss_cycles   <= 6'(cy);
    iss_paired   <= pr;
    @(posedge ref_clk);
  endtask
  // released masks flip so a stale value never looks like a request
  task automatic idle();
    iss_valid    <= 1'b0;
    iss_src_mask <= ~iss_src_mask;
    iss_dst_mask <= ~iss_dst_mask;
    @(posedge ref_clk);
  endtask
  // re-present until taken, at most 60 tries; nst counts refused attempts
  task automatic take(op_class_type c, int len, logic [31:0] s, d, int cy, bit pr,
                      output int nst);
    nst = 0;
    repeat (60) begin
      present(c, len, s, d, cy, pr);
      idle();
      if (iss_accept === 1'b1) break;
      nst++;
    end
  endtask
  // a vector arithmetic op is never directly followed by another OP_ARITH; a transfer is put between
  task automatic issue(op_class_type c, int len, logic [31:0] s, d, int cy, bit pr,
                       output int nst);
    int f;
    if (need_xfer && c == OP_ARITH) take(OP_LDST, 1, '0, '0, 1, 1'b0, f);
    take(c, len, s, d, cy, pr, nst);
    need_xfer = (c == OP_ARITH) && (len > 1);
  endtask
endmodule  // fp_host_model

// ### test/testbench.sv
// self-checking bench for the coprocessor issue and hazard control block
`timescale 1ns/100ps
`include "fp_issue_consts.svh"
module testbench;
  import fp_issue_pkg::*;
  // ****************
  // stimulus and checks
  // ****************
  localparam logic [31:0] FAST = (32'h1 << `BIT_FLUSH_ZERO) | (32'h1 << `BIT_DNAN);
  localparam logic [31:0] PAT  = 32'h9c3a_57e1;
  localparam logic [3:0]  SC   = `OFS_STATUS_CTRL;
  localparam logic [3:0]  IS   = `OFS_ISSUE_STATE;
  logic         ref_clk = 1'b0, nrst = 1'b0, clk_run = 1'b1, scan_en = 1'b0, scan_in = 1'b0;
  logic         bm = 1'b0, dv = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [4:0]   q = 5'h00;
  logic [3:0]   addr = 4'h0;
  logic [31:0]  dmask = 32'h0, wdata = 32'h0;
  op_class_type cls;
  logic         valid, paired, acc, stall, dnan, tsup, tusr, pair2, scan_out;
  logic [3:0]   len;
  logic [31:0]  src, dst, rdata;
  logic [5:0]   cyc;
  int           n_mismatch = 0, check_count = 0, st;
  // clock may be held still to show state survives
  always #10 if (clk_run) ref_clk = ~ref_clk;
  fp_issue_ctrl fp_issue_ctrl_inst (
    .ref_clk, .nrst, .scan_en, .scan_in, .scan_out, .iss_valid(valid), .iss_class(cls),
    .iss_double(1'b0), .iss_len(len), .iss_src_mask(src), .iss_dst_mask(dst),
    .iss_cycles(cyc), .iss_paired(paired), .branch_mispredict(bm), .iss_accept(acc),
    .iss_stall(stall), .op_done_valid(dv), .op_done_mask(dmask), .in_subnormal(q[4]),
    .in_qnan(q[3]), .in_snan(q[2]), .ovf_possible(q[1]), .res_tiny(q[0]),
    .use_default_nan(dnan), .trap_support(tsup), .trap_user(tusr),
    .paired_two_words(pair2), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata));
  fp_host_model fp_host_model_inst (
    .ref_clk, .iss_class(cls), .iss_valid(valid), .iss_len(len), .iss_src_mask(src),
    .iss_dst_mask(dst), .iss_cycles(cyc), .iss_paired(paired), .iss_accept(acc),
    .paired_two_words(pair2));
  function automatic logic [31:0] rg(int n);
    return 32'h1 << n;
  endfunction
  task automatic check32(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(logic got, logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(logic [3:0] a, logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_expect(logic [3:0] a, logic [31:0] exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    check32(rdata, exp);
  endtask
  // completion with qualifiers; pulses are read a cycle later
  task automatic complete(logic [31:0] m, logic [4:0] f);
    dv    <= 1'b1;
    dmask <= m;
    q     <= f;
    @(posedge ref_clk);
    dv <= 1'b0;
    q  <= 5'h00;
    @(posedge ref_clk);
  endtask
  task automatic iss(op_class_type c, int l, logic [31:0] s, d, int cy, bit pr = 1'b0);
    fp_host_model_inst.issue(c, l, s, d, cy, pr, st);
  endtask
  task automatic probe(op_class_type c, logic [31:0] s, d);
    fp_host_model_inst.present(c, 1, s, d, 1, 1'b0);
    fp_host_model_inst.idle();
  endtask
  task automatic t_regs();
    reg_expect(SC, `STATUS_CTRL_RST);
    reg_expect(IS, 32'h01);
    reg_expect(`OFS_SCAN_CTRL, 32'h0);
    reg_expect(4'h3, 32'h0);
    reg_write(SC, FAST);
    reg_expect(SC, FAST);
    reg_expect(IS, 32'h81);
    // any enable, or a missing setting, ends the fast condition
    for (int b = 8; b < 16; b++) begin
      if (b < 13 || b == 15) begin
        reg_write(SC, FAST | rg(b));
        reg_expect(IS, 32'h01);
      end
    end
    reg_write(SC, rg(`BIT_FLUSH_ZERO));
    reg_expect(IS, 32'h01);
    $display("t_regs done");
  endtask
  task automatic t_par();
    iss(OP_ARITH, 1, rg(1), rg(2), 20);
    iss(OP_LDST, 1, rg(8), rg(9), 1);
    check32(32'(st), 32'h0);
    iss(OP_DIVSQ, 1, rg(3), rg(4), 1);
    check32(32'(st), 32'h0);
    iss(OP_ARITH, 1, rg(5), rg(6), 2);
    check32(32'(st), 32'h0);
    iss(OP_DIVSQ, 1, rg(10), rg(11), 1);
    check_bit(1'(st > 0 && st < 60), 1'b1);
    complete('1, 5'h00);
    $display("t_par done");
  endtask
  task automatic t_serial();
    iss(OP_DIVSQ, 8, rg(12), rg(13), 1);
    probe(OP_ARITH, rg(14), rg(15));
    check_bit(stall, 1'b1);
    probe(OP_DIVSQ, rg(14), rg(15));
    check_bit(stall, 1'b1);
    complete('1, 5'h00);
    iss(OP_ARITH, 1, rg(1), '0, 12);
    iss(OP_CTRL, 1, '0, '0, 1);
    check_bit(1'(st > 0 && st < 60), 1'b1);
    iss(OP_ARITH, 1, rg(1), '0, 12);
    bm <= 1'b1;
    @(posedge ref_clk);
    bm <= 1'b0;
    iss(OP_LDST, 1, rg(9), rg(8), 1);
    check_bit(1'(st > 0 && st < 60), 1'b1);
    complete('1, 5'h00);
    $display("t_serial done");
  endtask
  task automatic t_rar();
    for (int f = 0; f < 2; f++) begin
      reg_write(SC, f ? FAST : 32'h0);
      fp_host_model_inst.present(OP_LDST, 1, rg(5), rg(6), 1, 1'b0);
      probe(OP_LDST, rg(5), rg(7));
      check_bit(stall, 1'(f == 0));
      complete('1, 5'h00);
      iss(OP_ARITH, 4, rg(16), rg(20), 8);
      probe(OP_LDST, '0, rg(16));
      check_bit(stall, 1'(f == 0));
      complete('1, 5'h00);
    end
    $display("t_rar done");
  endtask
  task automatic t_flags();
    int n0;
    n0 = fp_host_model_inst.n_pair;
    iss(OP_LDST, 1, '0, rg(2) | rg(3), 1, 1'b1);
    repeat (2) @(posedge ref_clk);
    check32(32'(fp_host_model_inst.n_pair - n0), 32'h1);
    complete('1, 5'h00);
    reg_write(SC, FAST);
    complete('0, 5'b01000);
    check_bit(dnan, 1'b1);
    check_bit(tsup | tusr, 1'b0);
    complete('0, 5'b10000);
    check_bit(tusr, 1'b0);
    complete('0, 5'b00001);
    check_bit(tusr | tsup, 1'b0);
    complete('0, 5'b00010);
    check_bit(tsup, 1'b0);
    reg_expect(SC, FAST | rg(`BIT_INPUT_DENORM) | rg(`BIT_UNDERFLOW));
    reg_write(SC, FAST | rg(`BIT_OVF_EN));
    complete('0, 5'b00010);
    check_bit(tsup, 1'b1);
    reg_write(SC, rg(`BIT_DNAN) | rg(`BIT_INV_EN));
    complete('0, 5'b00100);
    check_bit(tusr, 1'b1);
    reg_expect(SC, rg(`BIT_DNAN) | rg(`BIT_INV_EN) | rg(`BIT_INVALID));
    reg_write(SC, FAST | rg(`BIT_DENORM_TRAP));
    complete('0, 5'b10000);
    check_bit(tusr, 1'b1);
    reg_expect(SC, FAST | rg(`BIT_DENORM_TRAP) | rg(`BIT_INPUT_DENORM));
    $display("t_flags done");
  endtask
  // scan last: shifting only moves the 8-bit scan register; other state is untouched
  task automatic t_clk_scan();
    reg_write(SC, FAST);
    clk_run = 1'b0;
    #3000;
    clk_run = 1'b1;
    @(posedge ref_clk);
    reg_expect(SC, FAST);
    scan_en <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      scan_in <= PAT[i%32];
      @(posedge ref_clk);
      if (i >= 9) check_bit(scan_out, PAT[(i-9)%32]);
    end
    scan_en <= 1'b0;
    $display("t_clk_scan done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // the tests need a few hundred cycles
  initial begin
    #400000;
    n_mismatch++;
    $display("watchdog expired");
    results();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_par();
    t_serial();
    t_rar();
    t_flags();
    t_clk_scan();
    results();
  end
endmodule  // testbench
